// ==== rtl/dsef_pkg.sv ====
// constants and types for the debug status entry and sticky flag logic
// Operation
// - status bit 9 reserved, reads zero
// - sticky undefined flag set in debug state
// - run control bit 2 clears sticky flags
// - sticky async abort set in debug state
// - sticky sync abort set in debug state
// - sync abort blocks instruction transfer issue
// - sync abort blocks fast mode data access
// - entry cause field, reset halt request code
// - entry cause codes for each debug event
// - entry cause loaded on exception or entry
// - restarted bit low while leaving, reset one
// - halted bit high in debug state
// - halted, restarted and nonsecure bits reset on core reset
// - run control bit 1 requests leaving
// - fast mode data access issues instruction
package dsef_pkg;
  // ----------------------------------------
  // status register field positions
  // ----------------------------------------
  localparam int BIT_HALTED = 0;
  localparam int BIT_RESTARTED = 1;
  localparam int CAUSE_LO = 2;
  localparam int CAUSE_HI = 5;
  localparam int BIT_SYNC_ABT = 6;
  localparam int BIT_ASYNC_ABT = 7;
  localparam int BIT_UNDEF = 8;
  localparam int BIT_RSVD = 9;
  localparam int BIT_NONSECURE = 18;
  // run control bits
  localparam int RC_RESTART = 1;
  localparam int RC_CLR_STICKY = 2;
  // ----------------------------------------
  // entry cause codes
  // ----------------------------------------
  localparam logic [3:0] CAUSE_HALT_REQ = 4'h0;
  localparam logic [3:0] CAUSE_BREAKPOINT = 4'h1;
  localparam logic [3:0] CAUSE_UNSUPPORTED = 4'h2;
  localparam logic [3:0] CAUSE_BREAKPOINT_INSTRUCTION_INSTR = 4'h3;
  localparam logic [3:0] CAUSE_EXT_HALT = 4'h4;
  localparam logic [3:0] CAUSE_VECTOR_CATCH = 4'h5;
  localparam logic [3:0] CAUSE_WATCHPOINT = 4'hA;
  // reset values
  localparam logic RST_RESTARTED = 1'b1;
  localparam logic RST_HALTED = 1'b0;
  localparam logic RST_NONSECURE = 1'b0;
  // transfer access modes
  localparam logic [1:0] MODE_NONBLOCKING = 2'h0;
  localparam logic [1:0] MODE_STALL = 2'h1;
  localparam logic [1:0] MODE_FAST = 2'h2;
  // core run state
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALTED = 3'b010,
    ST_LEAVING = 3'b100
  } dsef_state_t;
endpackage

// ==== rtl/dsef_status.sv ====
// debug status register low bits, entry cause and sticky exception flags
`timescale 1ns/10ps
module dsef_status
  import dsef_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic debug_core_reset_n,
  // run control register write
  input wire logic run_control_wr,
  input wire logic [31:0] run_control_wdata,
  // status register write and read
  input wire logic status_wr,
  input wire logic [31:0] status_wdata,
  output logic [31:0] debug_status_control,
  // core events
  input wire logic halt_entry,
  input wire logic [3:0] halt_cause,
  input wire logic debug_exception,
  input wire logic [3:0] exception_cause,
  input wire logic exit_done,
  input wire logic undef_event,
  input wire logic async_abort_event,
  input wire logic sync_abort_event,
  input wire logic core_nonsecure,
  // transfer channel accesses
  input wire logic [1:0] transfer_access_mode,
  input wire logic itr_wr,
  input wire logic rx_ext_wr,
  input wire logic tx_ext_rd,
  output logic itr_wr_accept,
  output logic rx_ext_wr_accept,
  output logic tx_ext_rd_accept,
  output logic issue_instr,
  output logic restart_req
);
  logic rst_s1_q;
  logic rst_n_q;
  logic core_rst_n;
  dsef_state_t state_q;
  logic undef_q;
  logic async_q;
  logic sync_q;
  logic [3:0] cause_q;
  logic nonsec_q;
  logic in_debug;
  logic clr_sticky;
  logic fast_mode;
  logic xfer_ok;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  // two-flop release; core reset also hits core-status state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  assign core_rst_n = rst_n_q & debug_core_reset_n;

  assign in_debug = (state_q == ST_HALTED);
  assign clr_sticky = run_control_wr & run_control_wdata[RC_CLR_STICKY];
  assign fast_mode = (transfer_access_mode == MODE_FAST);

  // ----------------------------------------
  // run state: halted, leaving, running
  // ----------------------------------------
  // synchronous core reset, so the async edge only sees rstn
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_RUN;
    end else if (!core_rst_n) begin
      state_q <= ST_RUN;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (halt_entry) begin
            state_q <= ST_HALTED;
          end
        end
        ST_HALTED: begin
          if (run_control_wr && run_control_wdata[RC_RESTART]) begin
            state_q <= ST_LEAVING;
          end
        end
        ST_LEAVING: begin
          if (exit_done) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end
  // request held until exit completes; ignored outside debug state
  assign restart_req = (state_q == ST_LEAVING);

  // ----------------------------------------
  // sticky flags: set beats clear
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      undef_q <= 1'b0;
      async_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      if (in_debug && undef_event) begin
        undef_q <= 1'b1;
      end else if (clr_sticky) begin
        undef_q <= 1'b0;
      end
      if (in_debug && async_abort_event) begin
        async_q <= 1'b1;
      end else if (clr_sticky) begin
        async_q <= 1'b0;
      end
      if (in_debug && sync_abort_event) begin
        sync_q <= 1'b1;
      end else if (clr_sticky) begin
        sync_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // entry cause and secure status
  // ----------------------------------------
  // hardware load outranks a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cause_q <= CAUSE_HALT_REQ;
    end else if (state_q == ST_RUN && halt_entry) begin
      cause_q <= halt_cause;
    end else if (debug_exception) begin
      cause_q <= exception_cause;
    end else if (status_wr) begin
      cause_q <= status_wdata[CAUSE_HI:CAUSE_LO];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nonsec_q <= RST_NONSECURE;
    end else if (!core_rst_n) begin
      nonsec_q <= RST_NONSECURE;
    end else begin
      nonsec_q <= core_nonsecure;
    end
  end

  // ----------------------------------------
  // transfer gating
  // ----------------------------------------
  assign xfer_ok = !(sync_q && fast_mode);
  assign itr_wr_accept = itr_wr && !sync_q;
  assign rx_ext_wr_accept = rx_ext_wr && xfer_ok;
  assign tx_ext_rd_accept = tx_ext_rd && xfer_ok;
  // fast mode issues on data access, others on instruction write
  assign issue_instr = !sync_q && (fast_mode ? (rx_ext_wr || tx_ext_rd)
                                             : itr_wr);

  // ----------------------------------------
  // status read value
  // ----------------------------------------
  always_comb begin
    debug_status_control = '0;
    debug_status_control[BIT_HALTED] = in_debug;
    debug_status_control[BIT_RESTARTED] = (state_q != ST_LEAVING);
    debug_status_control[CAUSE_HI:CAUSE_LO] = cause_q;
    debug_status_control[BIT_SYNC_ABT] = sync_q;
    debug_status_control[BIT_ASYNC_ABT] = async_q;
    debug_status_control[BIT_UNDEF] = undef_q;
    debug_status_control[BIT_RSVD] = 1'b0;
    debug_status_control[BIT_NONSECURE] = nonsec_q;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    debug_status_control[BIT_RSVD] == 1'b0) else $error("reserved bit set");
  a_undef_set: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    in_debug && undef_event |=> undef_q) else $error("undef flag not set");
  a_clear_works: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    clr_sticky && !undef_event && !async_abort_event && !sync_abort_event
    |=> !undef_q && !async_q && !sync_q) else $error("sticky not cleared");
  a_async_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    async_q && !clr_sticky |=> async_q) else $error("async flag dropped");
  a_sync_set: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    in_debug && sync_abort_event && clr_sticky |=> sync_q)
    else $error("set lost to clear");
  a_itr_block: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    sync_q |-> !itr_wr_accept && !issue_instr) else $error("issue while blocked");
  a_fast_block: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    sync_q && fast_mode |-> !rx_ext_wr_accept && !tx_ext_rd_accept)
    else $error("fast access while blocked");
  a_cause_load: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    state_q == ST_RUN && halt_entry && core_rst_n
    |=> debug_status_control[CAUSE_HI:CAUSE_LO] == $past(halt_cause))
    else $error("cause not loaded");
  a_restart_seq: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    in_debug && run_control_wr && run_control_wdata[RC_RESTART] && core_rst_n
    |=> !debug_status_control[BIT_RESTARTED] && !debug_status_control[BIT_HALTED])
    else $error("leave sequence wrong");
  a_halt_bit: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    state_q == ST_RUN && halt_entry && core_rst_n |=> debug_status_control[BIT_HALTED])
    else $error("halted bit missing");
  a_core_reset: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !debug_core_reset_n |=> debug_status_control[BIT_RESTARTED] == RST_RESTARTED &&
    debug_status_control[BIT_HALTED] == RST_HALTED) else $error("core reset status");

  c_halt: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    state_q == ST_RUN ##1 in_debug);
  c_leave: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    state_q == ST_LEAVING ##1 state_q == ST_RUN);
  c_sync_block: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    sync_q && itr_wr);
  c_fast_issue: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
    fast_mode && issue_instr);
endmodule

// ==== verification/dsef_debugger_model.sv ====
// debugger model: register writes and bounded status polling
`timescale 1ns/10ps
module dsef_debugger_model (
  // clock and status read value
  input wire logic clk_sys,
  input wire logic [31:0] debug_status_control,
  // register writes
  output logic run_control_wr,
  output logic [31:0] run_control_wdata,
  output logic status_wr,
  output logic [31:0] status_wdata
);
  // idle at time zero
  initial begin
    run_control_wr = 1'b0;
    run_control_wdata = 32'h0;
    status_wr = 1'b0;
    status_wdata = 32'h0;
  end
  // one-cycle strobe; data inverted once released so stale values never match
  task automatic rc_write(input logic [31:0] d);
    @(posedge clk_sys);
    run_control_wr <= 1'b1;
    run_control_wdata <= d;
    @(posedge clk_sys);
    run_control_wr <= 1'b0;
    run_control_wdata <= ~d;
    #1;
  endtask
  // status write, same shape as run control
  task automatic st_write(input logic [31:0] d);
    @(posedge clk_sys);
    status_wr <= 1'b1;
    status_wdata <= d;
    @(posedge clk_sys);
    status_wr <= 1'b0;
    status_wdata <= ~d;
    #1;
  endtask
  // poll one status bit with a bounded count
  task automatic poll(input int b, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_sys);
      #1 ok = (debug_status_control[b] === 1'b1);
    end
  endtask
endmodule

// ==== verification/debug_status_entry_sticky_flags_test.sv ====
// self-checking bench for status bits, entry cause and sticky flags
`timescale 1ns/10ps
module debug_status_entry_sticky_flags_test;
  import dsef_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic core_rst_n = 1'b1;
  logic [5:0] ev = '0; // halt, exception, exit, undef, async, sync
  logic [3:0] cause = '0;
  logic [2:0] acc = '0; // itr write, rx write, tx read
  logic [1:0] mode = MODE_NONBLOCKING;
  logic nonsec = 1'b0;
  logic rc_wr, st_wr, itr_ok, rx_ok, tx_ok, issue, rreq, ok;
  logic [31:0] rc_d, st_d, st;
  int miscompares = 0;
  int compares = 0;
  // rows: halt cause in, expected entry cause field out
  logic [7:0] rows [6] = '{8'h00, 8'h11, 8'h33, 8'h44, 8'h55, 8'hAA};

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  dsef_status i_dut (.clk_sys(clk_sys), .rstn(rstn), .debug_core_reset_n(core_rst_n),
    .run_control_wr(rc_wr), .run_control_wdata(rc_d), .status_wr(st_wr),
    .status_wdata(st_d), .debug_status_control(st), .halt_entry(ev[5]),
    .halt_cause(cause), .debug_exception(ev[4]), .exception_cause(cause),
    .exit_done(ev[3]), .undef_event(ev[2]), .async_abort_event(ev[1]),
    .sync_abort_event(ev[0]), .core_nonsecure(nonsec), .transfer_access_mode(mode),
    .itr_wr(acc[2]), .rx_ext_wr(acc[1]), .tx_ext_rd(acc[0]), .itr_wr_accept(itr_ok),
    .rx_ext_wr_accept(rx_ok), .tx_ext_rd_accept(tx_ok), .issue_instr(issue),
    .restart_req(rreq));

  dsef_debugger_model i_dbg (.clk_sys(clk_sys), .debug_status_control(st),
    .run_control_wr(rc_wr), .run_control_wdata(rc_d), .status_wr(st_wr),
    .status_wdata(st_d));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle core event; returns once its update has landed
  task automatic pulse(input logic [5:0] m, input logic [3:0] c);
    @(posedge clk_sys);
    ev <= m;
    cause <= c;
    @(posedge clk_sys);
    ev <= '0;
    #1;
  endtask
  // access attempt; accepts and issue are combinational, looked at in-cycle
  task automatic try(input logic [2:0] a, input logic [3:0] exp);
    @(posedge clk_sys);
    acc <= a;
    #1 chk(32'({itr_ok, rx_ok, tx_ok, issue}), 32'(exp));
    @(posedge clk_sys);
    acc <= '0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    report_and_stop;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk(st, 32'h2);
    $display("reset test done");
    foreach (rows[i]) begin
      pulse(6'h20, rows[i][7:4]);
      chk(32'(st[5:0]), 32'({rows[i][3:0], 2'b11}));
      i_dbg.rc_write(32'h2);
      chk(32'({rreq, st[1:0]}), 32'h4);
      pulse(6'h08, 4'h0);
      i_dbg.poll(1, ok);
      chk(32'({ok, rreq, st[1:0]}), 32'hA);
    end
    $display("cause table test done");
    // restart while running must be ignored
    i_dbg.rc_write(32'h2);
    chk(32'({rreq, st[1:0]}), 32'h2);
    pulse(6'h10, CAUSE_WATCHPOINT);
    chk(32'(st[5:2]), 32'hA);
    i_dbg.st_write(32'h0000_0214);
    chk(32'(st[9:2]), 32'h5);
    $display("cause load test done");
    // sticky flags and the blocking they cause
    pulse(6'h20, CAUSE_EXT_HALT);
    pulse(6'h07, 4'h0);
    chk(32'(st[8:6]), 32'h7);
    // outside fast mode only the instruction path is blocked
    try(3'b111, 4'h6);
    @(posedge clk_sys);
    mode <= MODE_FAST;
    try(3'b011, 4'h0);
    i_dbg.rc_write(32'h4);
    chk(32'(st[8:6]), 32'h0);
    try(3'b010, 4'h5);
    try(3'b001, 4'h3);
    try(3'b100, 4'h8);
    // set and clear on one edge: set must win
    fork
      i_dbg.rc_write(32'h4);
      pulse(6'h05, 4'h0);
    join
    chk(32'(st[8:6]), 32'h5);
    $display("sticky flag test done");
    @(posedge clk_sys);
    nonsec <= 1'b1;
    @(posedge clk_sys);
    #1 chk(32'(st[18]), 32'h1);
    @(posedge clk_sys);
    core_rst_n <= 1'b0;
    @(posedge clk_sys);
    core_rst_n <= 1'b1;
    #1 chk(32'({st[18], st[8], st[1:0]}), 32'h6);
    $display("core reset test done");
    report_and_stop;
  end
endmodule
